/* common/cfr_pkg.sv */
// Shared constants and types for the charger fault response block
package cfr_pkg;

  // ----------------------------------------------------------------
  // Charge-state field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CFR_STAT_READY = 2'h0; // Ready
  localparam logic [1:0] CFR_STAT_CHG   = 2'h1; // Charge in progress
  localparam logic [1:0] CFR_STAT_DONE  = 2'h2; // Charge done
  localparam logic [1:0] CFR_STAT_FAULT = 2'h3; // Fault

  // ----------------------------------------------------------------
  // Thermistor fault field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] CFR_TS_NORMAL = 3'h0; // In range
  localparam logic [2:0] CFR_TS_COLD   = 3'h1; // Too cold
  localparam logic [2:0] CFR_TS_COOL   = 3'h2; // Cool, half current
  localparam logic [2:0] CFR_TS_WARM   = 3'h3; // Warm, lower target
  localparam logic [2:0] CFR_TS_HOT    = 3'h4; // Too hot

  // ----------------------------------------------------------------
  // Parameter source select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CFR_SRC_PIN     = 2'h0; // External pin
  localparam logic [1:0] CFR_SRC_DEFAULT = 2'h1; // Built-in default
  localparam logic [1:0] CFR_SRC_REG     = 2'h2; // Register value

  // ----------------------------------------------------------------
  // Derating figures
  // ----------------------------------------------------------------
  localparam int         CFR_WARM_DROP_MV  = 140;  // Warm target drop, mV
  localparam int         CFR_VREG_LSB_MV   = 10;   // Target step, mV
  localparam logic [7:0] CFR_WARM_DROP_CODE = 8'(CFR_WARM_DROP_MV / CFR_VREG_LSB_MV);
  localparam int         CFR_CHARGE_CURRENT_SETTING_SHIFT    = 1;    // Halving shift
  localparam logic [7:0] CFR_CODE_RST      = 8'h00; // Derated value reset

  // Interrupt pulse length in cycles (restarted by each new event)
  localparam logic [3:0] CFR_INT_CYCLES = 4'h4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       overVoltage;   // Input above OVP
    logic       underVoltage;  // Input below UVLO
    logic       currentLimit;  // Input current clamp active
    logic       dpmActive;     // Input-voltage DPM active
    logic       timerExpired;  // Safety timer expired
    logic [2:0] thermZone;     // Thermistor zone code
    logic       chargeDone;    // Termination reached
    logic       charging;      // Charger running
  } cfr_cond_t;

  typedef struct packed {
    logic       chargeEnable;   // Charger allowed
    logic       inputClamp;     // Input current clamped/reduced
    logic       systemRailEn;   // System rail on
    logic       systemFromBat;  // System rail fed from battery
    logic       loadSwitchEn;   // Load-switch output on
    logic       loadFromBat;    // Load-switch fed from battery
    logic       thermSenseEn;   // Thermistor sensing on
    logic       rechargeWatch;  // Watch for recharge threshold
  } cfr_gate_t;

  typedef struct packed {
    logic [1:0] pretermSrc;  // Precharge/termination source
    logic [1:0] chargeSrc;   // Charge current source
    logic [1:0] inLimitSrc;  // Input limit source
  } cfr_src_t;

endpackage : cfr_pkg

/* verilog/cfr_int_pulse.sv */
// Interrupt pulse stretcher for the charger fault response block
`timescale 1ns/1ps
`default_nettype none

module cfr_int_pulse
  import cfr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clkEn,
  input  wire logic trigger,
  input  wire logic enable,
  output var  logic intPulse
);

  // ----------------------------------------------------------------
  // Pulse counter
  // ----------------------------------------------------------------
  logic [3:0] count; // Cycles left in the pulse

  // Restarts on each trigger; a new event during a pulse extends it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 4'h0;
    end else if (clkEn) begin
      if (!enable) begin
        count <= 4'h0;
      end else if (trigger) begin
        count <= CFR_INT_CYCLES;
      end else if (count != 4'h0) begin
        count <= count - 4'h1;
      end
    end
  end

  // Output registered from the trigger and the counter state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intPulse <= 1'b0;
    end else if (clkEn) begin
      intPulse <= enable && (trigger || count > 4'h1);
    end
  end

endmodule : cfr_int_pulse

`default_nettype wire

/* verilog/cfr_fault_response.sv */
// Fault and status supervisor of the charge-management device
`timescale 1ns/1ps
`default_nettype none

module cfr_fault_response
  import cfr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      clkEn,
  input  wire cfr_cond_t cond,
  input  wire logic      shipMode,
  input  wire logic      hostAccessed,
  input  wire logic      systemRailCfg,
  input  wire logic      loadSwitchCfg,
  input  wire logic      preUseDefault,
  input  wire logic      preUseReg,
  input  wire logic      chgUseDefault,
  input  wire logic      chgUseReg,
  input  wire logic      limUseDefault,
  input  wire logic      limUseReg,
  input  wire logic      pushButton,
  input  wire logic [7:0] chargeCurrentCode,
  input  wire logic [7:0] regulationCode,
  output var  logic [1:0] chargeState,
  output var  logic      inputOvervoltageFlag,
  output var  logic      inputUndervoltageFlag,
  output var  logic      timerFaultFlag,
  output var  logic      inputDpmStatusFlag,
  output var  logic [2:0] thermistorFaultField,
  output var  logic      powerGoodOut,
  output var  logic      hostInterrupt,
  output var  cfr_gate_t gate,
  output var  cfr_src_t  source,
  output var  logic [7:0] chargeCurrentSetting,
  output var  logic [7:0] batteryRegulationTarget,
  output var  logic      buttonWake
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Pick the source for one parameter, pins before host access
  function automatic logic [1:0] pickSrc(input logic accessed, input logic useDef,
                                         input logic useReg);
    logic [1:0] s;
    s = CFR_SRC_PIN;
    if (accessed && useReg) begin
      s = CFR_SRC_REG;
    end else if (accessed && useDef) begin
      s = CFR_SRC_DEFAULT;
    end
    return s;
  endfunction : pickSrc

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  logic inputBad;   // Input outside its valid window
  logic thermCold;  // Cold or hot zone
  logic thermCool;  // Cool zone
  logic thermWarm;  // Warm zone
  logic anyFault;   // Any condition reported as fault
  logic [8:0] evNow;  // Present condition vector
  logic [8:0] evLast; // Previous condition vector
  logic newEvent;     // Rising edge on any condition

  // Both input faults lead to the same battery-fed posture
  assign inputBad  = cond.overVoltage || cond.underVoltage;
  assign thermCold = (cond.thermZone == CFR_TS_COLD) || (cond.thermZone == CFR_TS_HOT);
  assign thermCool = cond.thermZone == CFR_TS_COOL;
  assign thermWarm = cond.thermZone == CFR_TS_WARM;
  assign anyFault  = inputBad || cond.timerExpired || cond.dpmActive
                     || thermCold || thermCool || thermWarm;

  // Each condition whose onset interrupts the host
  assign evNow = {cond.overVoltage, cond.underVoltage, cond.currentLimit,
                  cond.dpmActive, cond.timerExpired, thermCold, thermCool,
                  thermWarm, cond.chargeDone};
  assign newEvent = |(evNow & ~evLast);

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  // Ship mode blanks history so an event on exit still interrupts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evLast <= 9'h000;
    end else if (clkEn) begin
      evLast <= shipMode ? 9'h000 : evNow;
    end
  end

  // ----------------------------------------------------------------
  // Status flags: follow the present condition only
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inputOvervoltageFlag  <= 1'b0;
      inputUndervoltageFlag <= 1'b0;
      timerFaultFlag        <= 1'b0;
      inputDpmStatusFlag    <= 1'b0;
      thermistorFaultField  <= CFR_TS_NORMAL;
    end else if (clkEn) begin
      // Undervoltage detection is the one survivor of ship mode
      inputUndervoltageFlag <= cond.underVoltage;
      inputOvervoltageFlag  <= !shipMode && cond.overVoltage;
      timerFaultFlag        <= !shipMode && cond.timerExpired;
      inputDpmStatusFlag    <= !shipMode && cond.dpmActive;
      thermistorFaultField  <= shipMode ? CFR_TS_NORMAL : cond.thermZone;
    end
  end

  // ----------------------------------------------------------------
  // Charge state field
  // ----------------------------------------------------------------
  // Fault outranks done, done outranks charging; no memory of the past
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chargeState <= CFR_STAT_READY;
    end else if (clkEn) begin
      if (shipMode) begin
        chargeState <= CFR_STAT_READY;
      end else if (anyFault) begin
        chargeState <= CFR_STAT_FAULT;
      end else if (cond.chargeDone) begin
        chargeState <= CFR_STAT_DONE;
      end else if (cond.charging || cond.currentLimit) begin
        chargeState <= CFR_STAT_CHG;
      end else begin
        chargeState <= CFR_STAT_READY;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power good
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerGoodOut <= 1'b0;
    end else if (clkEn) begin
      powerGoodOut <= !shipMode && !inputBad;
    end
  end

  // ----------------------------------------------------------------
  // Gating of charger, rails and thermistor sensing
  // ----------------------------------------------------------------
  // Recomputed each cycle, so gating releases when its cause clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate <= '0;
    end else if (clkEn) begin
      if (shipMode) begin
        gate <= '0;
      end else begin
        gate.chargeEnable  <= !(inputBad || cond.timerExpired || thermCold
                               || cond.chargeDone);
        gate.inputClamp    <= cond.currentLimit || cond.dpmActive;
        // Rails stay fed from the battery through an input fault
        gate.systemRailEn  <= inputBad || systemRailCfg;
        gate.systemFromBat <= inputBad;
        gate.loadSwitchEn  <= inputBad || loadSwitchCfg;
        gate.loadFromBat   <= inputBad;
        gate.thermSenseEn  <= !(inputBad || cond.timerExpired);
        gate.rechargeWatch <= cond.chargeDone;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parameter sources
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      source <= '0;
    end else if (clkEn) begin
      // Host choices also apply while charging
      source.pretermSrc <= pickSrc(hostAccessed || cond.charging, preUseDefault,
                                   preUseReg);
      source.chargeSrc  <= pickSrc(hostAccessed || cond.charging, chgUseDefault,
                                   chgUseReg);
      source.inLimitSrc <= pickSrc(hostAccessed || cond.charging, limUseDefault,
                                   limUseReg);
    end
  end

  // ----------------------------------------------------------------
  // Thermal derating of current and target
  // ----------------------------------------------------------------
  // Target floors at zero rather than wrapping on tiny codes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chargeCurrentSetting    <= CFR_CODE_RST;
      batteryRegulationTarget <= CFR_CODE_RST;
    end else if (clkEn) begin
      chargeCurrentSetting <= (thermCool && !shipMode)
                              ? (chargeCurrentCode >> CFR_CHARGE_CURRENT_SETTING_SHIFT)
                              : chargeCurrentCode;
      if (thermWarm && !shipMode) begin
        batteryRegulationTarget <= (regulationCode > CFR_WARM_DROP_CODE)
                                   ? regulationCode - CFR_WARM_DROP_CODE
                                   : 8'h00;
      end else begin
        batteryRegulationTarget <= regulationCode;
      end
    end
  end

  // ----------------------------------------------------------------
  // Push button stays alive in every mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buttonWake <= 1'b0;
    end else if (clkEn) begin
      buttonWake <= pushButton;
    end
  end

  // ----------------------------------------------------------------
  // Host interrupt, muted in ship mode
  // ----------------------------------------------------------------
  cfr_int_pulse intGen (
    .clk      (clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .trigger  (newEvent),
    .enable   (!shipMode),
    .intPulse (hostInterrupt)
  );

endmodule : cfr_fault_response

`default_nettype wire

/* verif/cfr_fault_response_props.sv */
// Port-level concurrent checks for the charger fault response block
`timescale 1ns/1ps
`default_nettype none

module cfr_fault_response_props
  import cfr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire cfr_cond_t  cond,
  input  wire logic       shipMode,
  input  wire logic [7:0] chargeCurrentCode,
  input  wire logic [7:0] regulationCode,
  input  wire logic [1:0] chargeState,
  input  wire logic       inputOvervoltageFlag,
  input  wire logic       inputUndervoltageFlag,
  input  wire logic       timerFaultFlag,
  input  wire logic       powerGoodOut,
  input  wire logic       hostInterrupt,
  input  wire cfr_gate_t  gate,
  input  wire logic [7:0] chargeCurrentSetting,
  input  wire logic [7:0] batteryRegulationTarget
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic live;   // Last edge ran with clkEn and outside reset
  logic quiet;  // No fault condition present at the inputs
  assign quiet = !(cond.overVoltage || cond.underVoltage || cond.timerExpired
                   || cond.dpmActive || (cond.thermZone != CFR_TS_NORMAL));

  // Live flag: keeps $past away from values taken during reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live <= 1'b0;
    end else begin
      live <= clkEn;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ov_response: assert property (live && $past(cond.overVoltage && !shipMode) |->
    chargeState == CFR_STAT_FAULT && inputOvervoltageFlag && !powerGoodOut && !gate.chargeEnable
    && !gate.thermSenseEn && gate.systemFromBat && gate.loadFromBat) else $error("ov response");
  a_uv_response: assert property (live && $past(cond.underVoltage && !shipMode) |->
    chargeState == CFR_STAT_FAULT && inputUndervoltageFlag && !powerGoodOut && !gate.chargeEnable
    && !gate.thermSenseEn && gate.systemFromBat && gate.loadFromBat) else $error("uv response");
  a_input_limit_pin_clamp: assert property (live && $past(cond.currentLimit && quiet && !cond.chargeDone
    && !shipMode) |-> chargeState == CFR_STAT_CHG && gate.inputClamp && gate.chargeEnable
    && gate.thermSenseEn) else $error("current limit response");
  a_timer_stop: assert property (live && $past(cond.timerExpired && !shipMode) |->
    chargeState == CFR_STAT_FAULT && timerFaultFlag && !gate.chargeEnable && !gate.thermSenseEn)
    else $error("timer response");
  a_cool_half: assert property (live && $past(cond.thermZone == CFR_TS_COOL && !shipMode) |->
    chargeCurrentSetting == ($past(chargeCurrentCode) >> CFR_CHARGE_CURRENT_SETTING_SHIFT)) else $error("cool derate");
  a_warm_drop: assert property (live && $past(cond.thermZone == CFR_TS_WARM && !shipMode) |->
    batteryRegulationTarget == (($past(regulationCode) > CFR_WARM_DROP_CODE)
    ? $past(regulationCode) - CFR_WARM_DROP_CODE : 8'h00)) else $error("warm derate");
  a_done_watch: assert property (live && $past(cond.chargeDone && quiet && !shipMode) |->
    chargeState == CFR_STAT_DONE && !gate.chargeEnable && gate.rechargeWatch)
    else $error("charge done response");
  a_int_stretch: assert property (live && clkEn && !shipMode && $rose(cond.overVoltage) |=>
    hostInterrupt [*4]) else $error("interrupt pulse length");
  a_ship_quiet: assert property (live && $past(shipMode) |-> chargeState == CFR_STAT_READY
    && gate == 8'h00 && !hostInterrupt && !powerGoodOut && !inputOvervoltageFlag)
    else $error("ship mode output");
endmodule : cfr_fault_response_props

bind cfr_fault_response cfr_fault_response_props u_props (.clk(clk), .rst(rst), .clkEn(clkEn),
  .cond(cond), .shipMode(shipMode), .chargeCurrentCode(chargeCurrentCode),
  .regulationCode(regulationCode), .chargeState(chargeState),
  .inputOvervoltageFlag(inputOvervoltageFlag), .inputUndervoltageFlag(inputUndervoltageFlag),
  .timerFaultFlag(timerFaultFlag), .powerGoodOut(powerGoodOut), .hostInterrupt(hostInterrupt),
  .gate(gate), .chargeCurrentSetting(chargeCurrentSetting),
  .batteryRegulationTarget(batteryRegulationTarget));
`default_nettype wire

/* verif/cfr_host_model.sv */
// Host side model: counts interrupt pulses seen on the interrupt line
`timescale 1ns/1ps
`default_nettype none

module cfr_host_model
  import cfr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hostInterrupt,
  output var  logic [7:0] irqCount
);
  logic lastIrq;  // Interrupt level at the previous edge

  // Rising-edge counter; a stretched pulse counts once, as a host would see it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqCount <= 8'h00;
      lastIrq  <= 1'b0;
    end else begin
      lastIrq <= hostInterrupt;
      if (hostInterrupt && !lastIrq) begin
        irqCount <= irqCount + 8'h01;
      end
    end
  end
endmodule : cfr_host_model
`default_nettype wire

/* verif/tb_charger_fault_response.sv */
// Self-checking testbench for the charger fault response block
`timescale 1ns/1ps
`default_nettype none

module tb_charger_fault_response
  import cfr_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and response signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] c;     // Condition bits
    logic       ship;  // Ship mode request
    logic [1:0] st;    // Expected charge state
    logic [3:0] pcte;  // Expected power good, charge en, sense en, interrupt
  } cfr_row_t;
  logic       clk, rst, clkEn, shipMode, hostAccessed, systemRailCfg, loadSwitchCfg;
  logic       preUseDefault, preUseReg, chgUseDefault, chgUseReg, limUseDefault, limUseReg;
  logic       pushButton, inputOvervoltageFlag, inputUndervoltageFlag, timerFaultFlag;
  logic       inputDpmStatusFlag, powerGoodOut, hostInterrupt, buttonWake;
  logic [7:0] chargeCurrentCode, regulationCode, chargeCurrentSetting, batteryRegulationTarget;
  logic [7:0] irqCount, irqBase;
  logic [1:0] chargeState;
  logic [2:0] thermistorFaultField;
  cfr_cond_t  cond, rc;
  cfr_gate_t  gate;
  cfr_src_t   source;
  int         miscompares, compares, cycles, highs;
  // Ordinary cases: idle, charging, each condition, ship mode
  localparam cfr_row_t ROWS [13] = '{{10'h000, 7'b0_00_1110}, {10'h001, 7'b0_01_1110},
    {10'h201, 7'b0_11_0001}, {10'h101, 7'b0_11_0001}, {10'h081, 7'b0_01_1111},
    {10'h041, 7'b0_11_1111}, {10'h021, 7'b0_11_1001}, {10'h005, 7'b0_11_1011},
    {10'h009, 7'b0_11_1111}, {10'h00D, 7'b0_11_1111}, {10'h011, 7'b0_11_1011},
    {10'h002, 7'b0_10_1011}, {10'h101, 7'b1_00_0000}};

  cfr_fault_response DUT (.clk(clk), .rst(rst), .clkEn(clkEn), .cond(cond), .shipMode(shipMode),
    .hostAccessed(hostAccessed), .systemRailCfg(systemRailCfg), .loadSwitchCfg(loadSwitchCfg),
    .preUseDefault(preUseDefault), .preUseReg(preUseReg), .chgUseDefault(chgUseDefault),
    .chgUseReg(chgUseReg), .limUseDefault(limUseDefault), .limUseReg(limUseReg),
    .pushButton(pushButton), .chargeCurrentCode(chargeCurrentCode),
    .regulationCode(regulationCode), .chargeState(chargeState),
    .inputOvervoltageFlag(inputOvervoltageFlag), .inputUndervoltageFlag(inputUndervoltageFlag),
    .timerFaultFlag(timerFaultFlag), .inputDpmStatusFlag(inputDpmStatusFlag),
    .thermistorFaultField(thermistorFaultField), .powerGoodOut(powerGoodOut),
    .hostInterrupt(hostInterrupt), .gate(gate), .source(source),
    .chargeCurrentSetting(chargeCurrentSetting),
    .batteryRegulationTarget(batteryRegulationTarget), .buttonWake(buttonWake));
  cfr_host_model u_host (.clk(clk), .rst(rst), .hostInterrupt(hostInterrupt), .irqCount(irqCount));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard; the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Settled reading: one time unit after the last edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic apply(input logic [9:0] c, input logic s);
    @(posedge clk);
    cond     <= cfr_cond_t'(c);
    shipMode <= s;
  endtask : apply

  task automatic conclude;
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, clkEn, shipMode, hostAccessed, systemRailCfg, loadSwitchCfg} = 6'b110001;
    {preUseDefault, preUseReg, chgUseDefault, chgUseReg, limUseDefault, limUseReg} = 6'b011000;
    {pushButton, miscompares, compares} = '0;
    cond = cfr_cond_t'(10'h000);
    chargeCurrentCode = 8'h65;
    regulationCode = 8'hC8;
    tick(12);
    check(chargeState, CFR_STAT_READY);
    check(gate, 8'h00);
    @(posedge clk);
    rst <= 1'b0;
    // Table rows, each entered from idle so the interrupt edge is fresh
    for (int i = 0; i < 13; i++) begin
      apply(10'h000, 1'b0);
      tick(8);
      check(chargeState, CFR_STAT_READY);
      check(gate.chargeEnable, 1'b1);
      irqBase = irqCount;
      rc = cfr_cond_t'(ROWS[i].c);
      apply(ROWS[i].c, ROWS[i].ship);
      tick(8);
      check(chargeState, ROWS[i].st);
      check(powerGoodOut, ROWS[i].pcte[3]);
      check(gate.chargeEnable, ROWS[i].pcte[2]);
      check(gate.thermSenseEn, ROWS[i].pcte[1]);
      check(irqCount - irqBase, 8'(ROWS[i].pcte[0]));
      check(inputOvervoltageFlag, rc.overVoltage & !ROWS[i].ship);
      check(inputUndervoltageFlag, rc.underVoltage);
      check(timerFaultFlag, rc.timerExpired & !ROWS[i].ship);
      check(inputDpmStatusFlag, rc.dpmActive & !ROWS[i].ship);
      check(thermistorFaultField, rc.thermZone);
      check(gate.inputClamp, (rc.currentLimit | rc.dpmActive) & !ROWS[i].ship);
      check(gate.systemRailEn, (rc.overVoltage | rc.underVoltage) & !ROWS[i].ship);
      check(gate.loadSwitchEn, !ROWS[i].ship);
      if (!ROWS[i].ship) begin
        check(gate.rechargeWatch, ROWS[i].st == CFR_STAT_DONE);
        check(chargeCurrentSetting, (rc.thermZone == CFR_TS_COOL) ? 8'h32 : 8'h65);
        check(batteryRegulationTarget, (rc.thermZone == CFR_TS_WARM) ? 8'hBA : 8'hC8);
      end
    end
    // Warm drop near the floor of the target code
    apply(10'h00D, 1'b0);
    regulationCode <= 8'h0E;
    tick(2);
    check(batteryRegulationTarget, 8'h00);
    @(posedge clk);
    regulationCode <= 8'h0F;
    tick(2);
    check(batteryRegulationTarget, 8'h01);
    // Sources: pins before host access, then the chosen ones
    apply(10'h000, 1'b0);
    tick(2);
    check(source, {CFR_SRC_PIN, CFR_SRC_PIN, CFR_SRC_PIN});
    @(posedge clk);
    hostAccessed <= 1'b1;
    tick(2);
    check(source, {CFR_SRC_REG, CFR_SRC_DEFAULT, CFR_SRC_PIN});
    apply(10'h001, 1'b0);
    hostAccessed <= 1'b0;
    tick(2);
    check(source, {CFR_SRC_REG, CFR_SRC_DEFAULT, CFR_SRC_PIN});
    // Rails follow their configuration, input faults force them on
    apply(10'h020, 1'b0);
    systemRailCfg <= 1'b1;
    loadSwitchCfg <= 1'b0;
    tick(2);
    check(gate.systemRailEn, 1'b1);
    check(gate.loadSwitchEn, 1'b0);
    apply(10'h200, 1'b0);
    tick(2);
    check(gate.loadSwitchEn, 1'b1);
    check(gate.loadFromBat, 1'b1);
    // Interrupt pulse length, counted cycle by cycle
    apply(10'h000, 1'b0);
    tick(8);
    highs = 0;
    apply(10'h200, 1'b0);
    repeat (10) begin
      tick(1);
      highs += int'(hostInterrupt === 1'b1);
    end
    check(8'(highs), 8'(CFR_INT_CYCLES));
    // Frozen clock enable holds the outputs
    apply(10'h000, 1'b0);
    tick(4);
    apply(10'h200, 1'b0);
    clkEn <= 1'b0;
    tick(4);
    check(chargeState, CFR_STAT_READY);
    @(posedge clk);
    clkEn <= 1'b1;
    tick(2);
    check(chargeState, CFR_STAT_FAULT);
    // Ship mode keeps the push button alive
    apply(10'h000, 1'b1);
    pushButton <= 1'b1;
    tick(3);
    check(buttonWake, 1'b1);
    check(hostInterrupt, 1'b0);
    // Reset in mid-run with a fault present
    apply(10'h200, 1'b0);
    tick(2);
    @(posedge clk);
    rst <= 1'b1;
    tick(2);
    check(chargeState, CFR_STAT_READY);
    check(hostInterrupt, 1'b0);
    @(posedge clk);
    rst <= 1'b0;
    tick(3);
    check(chargeState, CFR_STAT_FAULT);
    conclude();
  end
endmodule : tb_charger_fault_response
`default_nettype wire
